// ### verilog/afpd_pkg.sv
// Constants and carrier types for the host-side fast-page DRAM controller.
// Assumes one 100 MHz system clock and a DRAM module on plain strobe pins.
// Behaviour
// RULE1 - Memory holds 16,777,216 nine-bit words, each at a unique 24-bit address.
// RULE2 - Address goes out as row then column halves of 12 bits, latched by strobes.
// RULE3 - Write enable high selects read, low selects write.
// RULE4 - Device captures write data on the column strobe falling edge.
// RULE5 - Early write keeps device outputs off until the next column cycle.
// RULE6 - Every page cycle starts with a row strobe, then a column strobe.
// RULE7 - Column strobe may repeat under a held row strobe; raising row ends page.
// RULE8 - Both strobes high ends the cycle; device precharges while row is high.
// RULE9 - Controller visits all 4,096 rows at least every 64 ms.
// RULE10 - Counter refresh takes its row from the device internal counter.
// RULE11 - After power-up wait 100 us, then eight refresh cycles before use.
// RULE12 - Column strobe high means device outputs are high impedance.
// RULE13 - With column strobe low, outputs may hold last read data.
// RULE14 - Column strobe pulsed high for precharge time starts a fresh cycle.
// RULE15 - Each read meets the read hold against column or row strobe.
// RULE16 - Late column strobe stretches row access; column access time then governs.
// RULE17 - Only early writes are used; no late or read-modify-write cycles.
// RULE18 - Counter refresh keeps write enable high; low enters test mode.
// RULE19 - Hidden refresh toggles row strobe with column strobe held low.
// RULE20 - Strobe order around counter refresh enables the device refresh counter.
// RULE21 - Ninth bit has own in, out and column strobe, same protocol.
// RULE22 - Row-only refresh pulses row strobe with column strobes held high.
`default_nettype none

package afpd_pkg;
    localparam int ADDR_W     = 24;
    localparam int HALF_W     = 12;
    localparam int DATA_W     = 9;
    localparam int CLK_PS     = 10000;
    localparam int ROWS       = 4096;
    localparam int REF_MS     = 64;
    localparam int WAKE_US    = 100;
    localparam int WAKE_CYC_N = 8;
    // Strobe phase times in ns: row precharge, row-to-column, column pulse, access.
    localparam int T_RP_NS    = 60;
    localparam int T_RCD_NS   = 20;
    localparam int T_CAS_NS   = 20;
    localparam int T_RAC_NS   = 80;
    localparam int T_CP_NS    = 10;
    localparam int T_CSR_NS   = 10;
    localparam int T_RAS_NS   = 80;
    localparam int T_RAH_NS   = 10;
    localparam int TIM_W      = 8;
    localparam logic [TIM_W-1:0] RP_CYC  = TIM_W'((T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [TIM_W-1:0] RCD_CYC = TIM_W'((T_RCD_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [TIM_W-1:0] CAS_CYC = TIM_W'((T_CAS_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [TIM_W-1:0] RAC_CYC = TIM_W'((T_RAC_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [TIM_W-1:0] CP_CYC  = TIM_W'((T_CP_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [TIM_W-1:0] CSR_CYC = TIM_W'((T_CSR_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [TIM_W-1:0] RAS_CYC = TIM_W'((T_RAS_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [TIM_W-1:0] RAH_CYC = TIM_W'((T_RAH_NS * 1000 + CLK_PS - 1) / CLK_PS);
    // Longest refresh spacing rounds down, less slack for an access still running when
    // refresh falls due; wake-up pause rounds up.
    localparam int REF_SLACK    = 32;
    localparam int REF_GAP_DEF  = (REF_MS * 1000000 / (CLK_PS / 1000)) / ROWS - REF_SLACK;
    localparam int WAKE_CYC_DEF = (WAKE_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int LONG_W       = 20;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } afpd_req_t;

    typedef struct packed {
        logic              ras_n;
        logic              cas_n;
        logic              ninth_bit_column_strobe_n;
        logic              we_n;
        logic [HALF_W-1:0] addr;
    } afpd_pins_t;
endpackage : afpd_pkg

`default_nettype wire

// ### verilog/afpd_ctrl.sv
// Host controller driving a fast-page DRAM module through its strobe pins.
// Assumes a synchronous requester on clk_sys and a module wired to pins directly.
`default_nettype none

module afpd_ctrl #(
    parameter int REF_GAP  = afpd_pkg::REF_GAP_DEF,
    parameter int WAKE_CYC = afpd_pkg::WAKE_CYC_DEF
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire afpd_pkg::afpd_req_t        req,
    input  wire logic                       req_valid,
    output logic                            req_ready,
    output logic [afpd_pkg::DATA_W-1:0]     rd_data,
    output logic                            rd_valid,
    output logic                            init_done,
    output afpd_pkg::afpd_pins_t            pins,
    output logic [7:0]                      shared_data_bits_o,
    output logic [7:0]                      shared_data_bits_oe,
    input  wire logic [7:0]                 shared_data_bits_i,
    output logic                            ninth_bit_data_in,
    input  wire logic                       ninth_bit_data_out
);
    import afpd_pkg::*;

    typedef enum logic [3:0] {
        S_WAKE, S_IDLE, S_PRE, S_ROW, S_COL, S_CPRE, S_CBR_CAS, S_CBR_RAS, S_CBR_END
    } afpd_state_t;

    afpd_state_t          state_r;
    logic [TIM_W-1:0]     tim_r;
    logic [LONG_W-1:0]    long_r;
    logic [3:0]           wake_left_r;
    logic                 ref_due_r;
    logic                 page_open_r;
    logic [HALF_W-1:0]    row_r;
    logic                 wr_r;
    logic [HALF_W-1:0]    col_r;
    logic [DATA_W-1:0]    wd_r;
    logic [DATA_W-1:0]    din_s1_r;
    logic [DATA_W-1:0]    din_s2_r;
    logic                 sample_r;

    // Pin data passes two flops; the strobe timing hides this lag.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            din_s1_r <= '0;
            din_s2_r <= '0;
        end else begin
            din_s1_r <= {ninth_bit_data_out, shared_data_bits_i};
            din_s2_r <= din_s1_r;
        end
    end

    // Refresh pacing and the power-up pause share one long counter.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            long_r    <= '0;
            ref_due_r <= 1'b0;
        end else if (state_r == S_WAKE && wake_left_r == WAKE_CYC_N[3:0]) begin
            if (long_r != LONG_W'(WAKE_CYC)) long_r <= long_r + 1'b1; // RULE11
        end else if (state_r == S_CBR_RAS) begin
            long_r    <= '0;
            ref_due_r <= 1'b0;
        end else if (long_r >= LONG_W'(REF_GAP - 1)) begin
            ref_due_r <= 1'b1; // RULE9
        end else begin
            long_r <= long_r + 1'b1;
        end
    end

    // Page hits stay under the open row; anything else closes it first.
    wire page_hit = page_open_r && req.addr[ADDR_W-1:HALF_W] == row_r; // RULE7
    wire take     = req_valid && req_ready;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= S_WAKE;
            tim_r       <= '0;
            wake_left_r <= WAKE_CYC_N[3:0];
            page_open_r <= 1'b0;
            row_r       <= '0;
            col_r       <= '0;
            wr_r        <= 1'b0;
            wd_r        <= '0;
            sample_r    <= 1'b0;
        end else begin
            sample_r <= 1'b0;
            if (tim_r != '0) begin
                tim_r <= tim_r - 1'b1;
            end else begin
                unique case (state_r)
                    S_WAKE: begin
                        if (long_r == LONG_W'(WAKE_CYC)) begin
                            state_r <= S_CBR_CAS;
                            tim_r   <= RP_CYC;
                        end
                    end
                    S_IDLE: begin
                        // Refresh starts from idle strobes only: no hidden or row-only cycles.
                        if (ref_due_r) begin
                            page_open_r <= 1'b0;
                            state_r     <= S_CBR_CAS; // RULE9 RULE19 RULE22
                            tim_r       <= RP_CYC;
                        end else if (take) begin
                            {wr_r, row_r, col_r, wd_r} <= req; // RULE2
                            if (page_hit) begin
                                // One set-up cycle puts address, data and write enable ahead of
                                // the column strobe.
                                state_r <= S_ROW; // RULE7
                                tim_r   <= '0;
                            end else if (page_open_r) begin
                                page_open_r <= 1'b0;
                                state_r     <= S_PRE; // RULE8
                                tim_r       <= RP_CYC;
                            end else begin
                                state_r <= S_ROW; // RULE6
                                tim_r   <= RCD_CYC;
                            end
                        end
                    end
                    S_PRE: begin
                        state_r <= S_ROW;
                        tim_r   <= RCD_CYC;
                    end
                    S_ROW: begin
                        page_open_r <= 1'b1;
                        state_r     <= S_COL;
                        tim_r       <= page_open_r ? CAS_CYC : RAC_CYC - RCD_CYC; // RULE16
                    end
                    S_COL: begin
                        sample_r <= !wr_r;
                        state_r  <= S_CPRE;
                        tim_r    <= CP_CYC; // RULE14
                    end
                    S_CPRE: state_r <= S_IDLE;
                    S_CBR_CAS: begin
                        state_r <= S_CBR_RAS;
                        tim_r   <= CSR_CYC;
                    end
                    S_CBR_RAS: begin
                        state_r <= S_CBR_END;
                        tim_r   <= RAS_CYC;
                    end
                    S_CBR_END: begin
                        tim_r <= RP_CYC; // RULE8
                        if (wake_left_r != '0) begin
                            wake_left_r <= wake_left_r - 1'b1;
                            state_r     <= (wake_left_r == 4'h1) ? S_IDLE : S_CBR_CAS; // RULE11
                        end else begin
                            state_r <= S_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Pin drive: every output comes from a flop.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pins                <= '{1'b1, 1'b1, 1'b1, 1'b1, '0};
            shared_data_bits_o  <= '0;
            shared_data_bits_oe <= '0;
            ninth_bit_data_in   <= 1'b0;
        end else begin
            unique case (state_r)
                S_ROW: begin
                    pins.ras_n <= 1'b0;
                    pins.addr  <= (tim_r < RCD_CYC - RAH_CYC) ? col_r : row_r; // RULE2
                    pins.we_n  <= !wr_r; // RULE3 RULE17
                    {ninth_bit_data_in, shared_data_bits_o} <= wd_r;
                    shared_data_bits_oe <= {8{wr_r}};
                end
                S_COL: begin
                    pins.ras_n  <= 1'b0;
                    pins.addr   <= col_r;
                    pins.we_n   <= !wr_r; // RULE17
                    pins.cas_n  <= 1'b0; // RULE4 RULE21
                    pins.ninth_bit_column_strobe_n <= 1'b0;
                    {ninth_bit_data_in, shared_data_bits_o} <= wd_r;
                    shared_data_bits_oe <= {8{wr_r}};
                end
                S_CPRE, S_IDLE: begin
                    pins.cas_n  <= 1'b1; // RULE12
                    pins.ninth_bit_column_strobe_n <= 1'b1;
                    pins.ras_n  <= !page_open_r;
                    pins.we_n   <= 1'b1; // RULE15
                    shared_data_bits_oe <= '0;
                end
                S_CBR_CAS: begin
                    pins.ras_n  <= 1'b1;
                    pins.we_n   <= 1'b1; // RULE18
                    pins.cas_n  <= (tim_r == '0) ? 1'b0 : 1'b1; // RULE10 RULE20
                    pins.ninth_bit_column_strobe_n <= (tim_r == '0) ? 1'b0 : 1'b1;
                    shared_data_bits_oe <= '0;
                end
                S_CBR_RAS: pins.ras_n <= (tim_r == '0) ? 1'b0 : 1'b1;
                S_CBR_END: begin
                    // Column strobe stays low until the row strobe rises, covering the hold time.
                    pins.cas_n <= (tim_r == '0) ? 1'b1 : 1'b0; // RULE20
                    pins.ninth_bit_column_strobe_n <= (tim_r == '0) ? 1'b1 : 1'b0;
                    pins.ras_n <= (tim_r == '0) ? 1'b1 : 1'b0;
                end
                default: begin
                    pins.ras_n <= 1'b1;
                    pins.cas_n <= 1'b1;
                    pins.ninth_bit_column_strobe_n <= 1'b1;
                    pins.we_n  <= 1'b1;
                    shared_data_bits_oe <= '0;
                end
            endcase
        end
    end

    // Read data is sampled while the column strobe is still low.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data   <= '0;
            rd_valid  <= 1'b0;
            req_ready <= 1'b0;
            init_done <= 1'b0;
        end else begin
            rd_valid  <= sample_r; // RULE13
            if (sample_r) rd_data <= din_s2_r;
            req_ready <= state_r == S_IDLE && !ref_due_r && !take && tim_r == '0
                         && long_r < LONG_W'(REF_GAP - 1);
            if (state_r == S_IDLE) init_done <= 1'b1;
        end
    end
endmodule : afpd_ctrl

`default_nettype wire

// ### tb/afpd_ctrl_checker.sv
// Port-level protocol checker for the fast-page DRAM controller.
// Assumes a single clk_sys domain and the strobe carrier of the package.
`default_nettype none
module afpd_ctrl_checker
    import afpd_pkg::*;
#(
    parameter int REF_GAP  = 200,
    parameter int WAKE_CYC = 20
) (
    input wire logic                 clk_sys,
    input wire logic                 rst_n,
    input wire logic                 req_ready,
    input wire logic                 rd_valid,
    input wire logic                 init_done,
    input wire afpd_pkg::afpd_pins_t pins,
    input wire logic [7:0]           shared_data_bits_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_cbr_we; $fell(pins.ras_n) && !pins.cas_n |-> pins.we_n; endproperty
    a_cbr_we: assert property (p_cbr_we) else $error("Counter refresh with write low.");
    property p_ninth; pins.cas_n == pins.ninth_bit_column_strobe_n; endproperty
    a_ninth: assert property (p_ninth) else $error("Column strobes differ.");
    property p_oe_wr; |shared_data_bits_oe |-> !pins.we_n; endproperty
    a_oe_wr: assert property (p_oe_wr) else $error("Data driven outside a write.");
    property p_row_first; $fell(pins.cas_n) && !pins.ras_n |-> !$past(pins.ras_n, 2); endproperty
    a_row_first: assert property (p_row_first) else $error("Column before row.");
    property p_prech; $rose(pins.ras_n) |-> pins.ras_n [*6]; endproperty
    a_prech: assert property (p_prech) else $error("Row precharge too short.");
    property p_cbr_setup; $fell(pins.ras_n) && !pins.cas_n |-> !$past(pins.cas_n); endproperty
    a_cbr_setup: assert property (p_cbr_setup) else $error("Refresh setup missing.");
    property p_cbr_hold; $fell(pins.ras_n) && !pins.cas_n |=> !pins.cas_n; endproperty
    a_cbr_hold: assert property (p_cbr_hold) else $error("Refresh hold too short.");
    property p_wake; !init_done |-> !req_ready; endproperty
    a_wake: assert property (p_wake) else $error("Ready before wake-up.");
    property p_rd_hold; !pins.ras_n && !pins.cas_n && pins.we_n |=> pins.we_n || pins.cas_n;
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("Write enable fell in a read.");
    c_read: cover property (rd_valid);
    c_cbr: cover property ($fell(pins.ras_n) && !pins.cas_n);
    c_write: cover property ($fell(pins.cas_n) && !pins.we_n);
endmodule : afpd_ctrl_checker

bind afpd_ctrl afpd_ctrl_checker #(.REF_GAP(REF_GAP), .WAKE_CYC(WAKE_CYC)) u_afpd_ctrl_checker (
    .clk_sys(clk_sys), .rst_n(rst_n), .req_ready(req_ready), .rd_valid(rd_valid),
    .init_done(init_done), .pins(pins), .shared_data_bits_oe(shared_data_bits_oe));
`default_nettype wire

// ### tb/afpd_dram_model.sv
// Behavioural fast-page DRAM module reacting to strobe edges only.
// Assumes the controller drives the shared bits only during writes.
`default_nettype none
module afpd_dram_model
    import afpd_pkg::*;
(
    input  wire afpd_pkg::afpd_pins_t pins,
    input  wire logic [7:0]           dq_o,
    input  wire logic [7:0]           dq_oe,
    input  wire logic                 d9,
    output logic [7:0]                dq_i,
    output logic                      q9,
    output int                        cbr_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] dout = 9'h0a5;
    logic [HALF_W-1:0] row  = 12'h000;
    logic [HALF_W-1:0] ctr  = 12'h000;
    logic              drv  = 1'b0;
    initial cbr_cnt = 0;
    always @(negedge pins.ras_n) begin
        if (!pins.cas_n) begin
            if (pins.we_n) begin
                row = ctr;
                ctr = ctr + 12'h001;
                cbr_cnt = cbr_cnt + 1;
            end
        end else begin
            row = pins.addr;
        end
    end
    always @(negedge pins.cas_n) begin
        if (!pins.ras_n && !pins.we_n) begin
            mem[{row, pins.addr}] = {d9, dq_o};
        end else if (!pins.ras_n) begin
            dout = mem.exists({row, pins.addr}) ? mem[{row, pins.addr}] : 9'h1c3;
            drv = 1'b1;
        end
    end
    // Released lines show the inverse of the last value, so late sampling is caught.
    always @(posedge pins.cas_n) drv = 1'b0;
    assign q9 = drv ? dout[8] : ~dout[8];
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            dq_i[i] = dq_oe[i] ? dq_o[i] : (drv ? dout[i] : ~dout[i]);
        end
    end
endmodule : afpd_dram_model
`default_nettype wire

// ### tb/async_fast_page_dram_port_bench.sv
// Self-checking bench for the fast-page DRAM controller and a module model.
// Assumes short wake-up and refresh spacing parameters to keep the run brief.
`default_nettype none
module async_fast_page_dram_port_bench
    import afpd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk_sys   = 1'b0;
    logic              rst_n     = 1'b0;
    afpd_req_t         req       = '0;
    logic              req_valid = 1'b0;
    logic              req_ready, rd_valid, init_done, d9, q9;
    logic [DATA_W-1:0] rd_data;
    afpd_pins_t        pins;
    logic [7:0]        dq_o, dq_oe, dq_i;
    int                cbr_cnt, errors = 0, checked = 0;
    logic [DATA_W-1:0] expq [$];
    logic [DATA_W-1:0] shadow [int];
    logic [ADDR_W-1:0] al [$];
    always #5 clk_sys = ~clk_sys;
    afpd_ctrl #(.REF_GAP(200), .WAKE_CYC(20)) u_afpd_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
        .req(req), .req_valid(req_valid), .req_ready(req_ready), .rd_data(rd_data),
        .rd_valid(rd_valid), .init_done(init_done), .pins(pins), .shared_data_bits_o(dq_o),
        .shared_data_bits_oe(dq_oe), .shared_data_bits_i(dq_i), .ninth_bit_data_in(d9),
        .ninth_bit_data_out(q9));
    afpd_dram_model u_afpd_dram_model (.pins(pins), .dq_o(dq_o), .dq_oe(dq_oe), .d9(d9),
        .dq_i(dq_i), .q9(q9), .cbr_cnt(cbr_cnt));
    task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        #1;
        req <= '{write: wr, addr: a, wdata: d};
        req_valid <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (req_ready !== 1'b1 && n < 2000);
        check("req taken", 9'(req_ready === 1'b1), 9'h001);
        if (!wr) expq.push_back(d);
        #1 req_valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask : access
    task automatic run();
        foreach (al[i]) begin
            shadow[al[i]] = 9'($urandom);
            access(1'b1, al[i], shadow[al[i]]);
        end
        foreach (al[i]) access(1'b0, al[i], shadow[al[i]]);
    endtask : run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // Each returned word is matched against the oldest outstanding read.
    always @(posedge clk_sys) begin
        if (rd_valid === 1'b1) begin
            if (expq.size() == 0) check("stray read", 9'h000, 9'h1ff);
            else check("read data", rd_data, expq.pop_front());
        end
    end
    initial begin
        #200000;
        errors++;
        $display("[ERR] watchdog expected finish seen hang");
        tally_and_finish();
    end
    initial begin
        int n;
        int c0;
        void'($urandom(15188));
        repeat (3) @(posedge clk_sys);
        check("idle strobes", 9'({pins.ras_n, pins.cas_n, pins.we_n}), 9'h007);
        repeat (3) @(posedge clk_sys);
        #1 rst_n <= 1'b1;
        for (n = 0; n < 3000 && init_done !== 1'b1; n++) @(posedge clk_sys);
        check("init done", 9'(init_done === 1'b1), 9'h001);
        check("wake refresh", 9'(cbr_cnt >= WAKE_CYC_N), 9'h001);
        $display("test 1 wake-up done");
        al = '{};
        n = int'(12'($urandom));
        al.push_back({12'(n), 12'h000});
        al.push_back({12'(n), 12'hfff});
        repeat (2) al.push_back({12'(n), 12'($urandom)});
        run();
        $display("test 2 page access done");
        al = '{24'h000000, 24'hffffff};
        repeat (6) al.push_back(24'($urandom));
        run();
        $display("test 3 row change done");
        c0 = cbr_cnt;
        repeat (600) @(posedge clk_sys);
        check("refresh pace", 9'(cbr_cnt - c0 >= 2), 9'h001);
        foreach (al[i]) access(1'b0, al[i], shadow[al[i]]);
        for (n = 0; n < 500 && expq.size() != 0; n++) @(posedge clk_sys);
        check("reads left", 9'(expq.size()), 9'h000);
        $display("test 4 retention done");
        tally_and_finish();
    end
endmodule : async_fast_page_dram_port_bench
`default_nettype wire
